// *** include/dpuc_map.svh ***
// Purpose: Register offsets, field positions, reset values and timing counts
// Assumes: 8-bit register port, one word per offset
// Notes:   Offsets are local choices; none are printed for this block
// Notes on behaviour
// - Conversion runs only while run-enable bit 4 of mode register is 1.
// - Channel 0 request flag, bit 4 of flag register, is 1 while pending.
// - Mask bit 0 lets a pending request through; 1 blocks it.
// - Writing 1 to start bit 0 sets enabled status and enables counting.
// - Writing 0 to start bit 0 changes nothing.
// - When counting actually begins depends on the selected channel mode.
// - Analog output follows the 8-bit conversion value; all bits writable.
// - Output level equals reference times conversion value divided by 256.
// - Mode register bit 0 selects normal mode (0) or real-time mode (1).
// - Clock gate bit 7 low holds converter in reset and blocks writes.
`ifndef DPUC_MAP_SVH
`define DPUC_MAP_SVH

// ==========================================================
// Register offsets
`define DPUC_OFF_MODE      4'h0
`define DPUC_OFF_IRQ_FLAG  4'h1
`define DPUC_OFF_IRQ_MASK  4'h2
`define DPUC_OFF_START_LO  4'h3
`define DPUC_OFF_START_HI  4'h4
`define DPUC_OFF_VALUE     4'h5
`define DPUC_OFF_CLK_GATE  4'h6
`define DPUC_OFF_RELOAD_LO 4'h7
`define DPUC_OFF_RELOAD_HI 4'h8
`define DPUC_OFF_CH_MODE   4'h9
`define DPUC_OFF_STATUS    4'ha
`define DPUC_OFF_INT_STAT  4'hb
`define DPUC_OFF_INT_MASK  4'hc

// ==========================================================
// Field positions
`define DPUC_BIT_RUN_EN    4
`define DPUC_BIT_MODE_SEL  0
`define DPUC_BIT_TMR_IRQ   4
`define DPUC_BIT_START     0
`define DPUC_BIT_CLK_GATE  7
`define DPUC_BIT_ENABLED   0
`define DPUC_BIT_COUNTING  1

// ==========================================================
// Reset values
`define DPUC_RST_MODE      8'h00
`define DPUC_RST_VALUE     8'h00
`define DPUC_RST_IRQ_FLAG  8'h00
`define DPUC_RST_IRQ_MASK  8'hff
`define DPUC_RST_RELOAD    16'h3e7f
`define DPUC_RST_INT_MASK  8'h00

// ==========================================================
// Timing
`define DPUC_CLK_MHZ       200
`define DPUC_STEPS         256

`endif

// *** include/dpuc_pkg.sv ***
// Purpose: Types shared by the converter control block
// Assumes: dpuc_map.svh holds all register map numbers; state and channel mode codes are set here
// Notes:   Types only
package dpuc_pkg;

  typedef enum logic [1:0] {
    DPUC_IDLE  = 2'b00,
    DPUC_ARMED = 2'b01,
    DPUC_COUNT = 2'b11
  } dpuc_state_t;

  typedef enum logic [1:0] {
    DPUC_CH_INTERVAL = 2'b00,
    DPUC_CH_EVENT    = 2'b01,
    DPUC_CH_ONESHOT  = 2'b10,
    DPUC_CH_RSVD     = 2'b11
  } dpuc_ch_mode_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } dpuc_bus_req_t;

  typedef struct packed {
    logic       run_en;
    logic       rt_mode;
    logic [7:0] value;
  } dpuc_conv_t;

endpackage

// *** verilog/dpuc_pwm_out.sv ***
// Purpose: 8-bit duty-cycle converter core for the analog output pin
// Assumes: Pin is filtered externally to reference * code / 256
// Notes:   Holds output low while disabled
`timescale 1ns/10ps
`default_nettype none
`include "dpuc_map.svh"

module dpuc_pwm_out
  import dpuc_pkg::*;
(
  input  wire logic       clock_i,  // System clock
  input  wire logic       rst_i,    // Async reset, high
  input  wire dpuc_conv_t conv_i,   // Run, mode, code
  input  wire logic       load_i,   // Real-time load pulse
  output logic            pin_o     // Analog output pin
);

  logic [7:0] phase_r;
  logic [7:0] code_r;

  // ==========================================================
  // Phase counter spans 256 steps
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      phase_r <= 8'h00;
    end else if (conv_i.run_en) begin
      phase_r <= phase_r + 8'h01;
    end else begin
      phase_r <= 8'h00;
    end
  end

  // ==========================================================
  // Code latch: direct in normal mode, on trigger in real-time mode
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      code_r <= `DPUC_RST_VALUE;
    end else if (!conv_i.rt_mode || load_i) begin
      code_r <= conv_i.value;
    end
  end

  // High for code/256 of each period, so mean level is ref*code/256
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      pin_o <= 1'b0;
    end else begin
      pin_o <= conv_i.run_en && (phase_r < code_r);
    end
  end

endmodule
`default_nettype wire

// *** verilog/dpuc_top.sv ***
// Purpose: Periodic converter update control with timer channel 0
// Assumes: Plain register port, read data one cycle after strobe
// Notes:   Timer interrupt also serves as real-time load trigger
//
// Added by the designer: the register offsets and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
`include "dpuc_map.svh"

module dpuc_top
  import dpuc_pkg::*;
(
  input  wire logic       clock_i,    // 200 MHz clock
  input  wire logic       rst_i,      // Async reset, high
  input  wire logic [3:0] addr_i,     // Register address
  input  wire logic [7:0] wdata_i,    // Write data
  input  wire logic       wr_i,       // Write strobe
  input  wire logic       rd_i,       // Read strobe
  input  wire logic       evt_pin_i,  // Event count input pin
  output logic      [7:0] rdata_o,    // Read data
  output logic            irq_o,      // Level interrupt
  output logic            tmr_irq_o,  // Channel 0 service request
  output logic            pin_o       // Analog output pin
);

  dpuc_bus_req_t req;
  logic          gate_r;
  logic [7:0]    mode_r;
  logic [7:0]    value_r;
  logic [7:0]    flag_r;
  logic [7:0]    mask_r;
  logic [15:0]   reload_r;
  logic [15:0]   count_r;
  dpuc_ch_mode_t ch_mode_r;
  dpuc_state_t   state_r;
  logic          enabled_r;
  logic [7:0]    ist_r;
  logic [7:0]    imask_r;
  logic [2:0]    evt_sync_r;
  logic          evt_edge;
  logic          conv_rst;
  logic          start_wr;
  logic          tick;
  logic          wr_conv;
  dpuc_conv_t    conv;
  logic [7:0]    events;

  assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};
  assign conv_rst = !gate_r;
  assign wr_conv  = req.wr && gate_r;
  assign start_wr = req.wr && (req.addr == `DPUC_OFF_START_LO)
                    && req.wdata[`DPUC_BIT_START];

  // ==========================================================
  // Clock gate register, always writable
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      gate_r <= 1'b0;
    end else if (req.wr && req.addr == `DPUC_OFF_CLK_GATE) begin
      gate_r <= req.wdata[`DPUC_BIT_CLK_GATE];
    end
  end

  // ==========================================================
  // Converter registers, held in reset while gate is off
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      mode_r  <= `DPUC_RST_MODE;
      value_r <= `DPUC_RST_VALUE;
    end else if (conv_rst) begin
      mode_r  <= `DPUC_RST_MODE;
      value_r <= `DPUC_RST_VALUE;
    end else if (wr_conv && req.addr == `DPUC_OFF_MODE) begin
      mode_r  <= req.wdata;
    end else if (wr_conv && req.addr == `DPUC_OFF_VALUE) begin
      value_r <= req.wdata;
    end
  end

  // ==========================================================
  // Timer channel configuration
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      reload_r  <= `DPUC_RST_RELOAD;
      ch_mode_r <= DPUC_CH_INTERVAL;
    end else if (req.wr) begin
      if (req.addr == `DPUC_OFF_RELOAD_LO) begin
        reload_r[7:0] <= req.wdata;
      end
      if (req.addr == `DPUC_OFF_RELOAD_HI) begin
        reload_r[15:8] <= req.wdata;
      end
      if (req.addr == `DPUC_OFF_CH_MODE) begin
        ch_mode_r <= dpuc_ch_mode_t'(req.wdata[1:0]);
      end
    end
  end

  // ==========================================================
  // Event pin synchroniser; edge seen only after second stage
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      evt_sync_r <= 3'b000;
    end else begin
      evt_sync_r <= {evt_sync_r[1:0], evt_pin_i};
    end
  end
  assign evt_edge = evt_sync_r[1] && !evt_sync_r[2];

  // ==========================================================
  // Channel 0 sequencer
  // Start writes of 0 fall through untouched; no stop register here.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      state_r   <= DPUC_IDLE;
      enabled_r <= 1'b0;
      count_r   <= 16'h0000;
    end else begin
      unique case (state_r)
        DPUC_IDLE: begin
          if (start_wr) begin
            enabled_r <= 1'b1;
            state_r   <= DPUC_ARMED;
          end
        end
        DPUC_ARMED: begin
          // Start moment differs by channel mode
          if (ch_mode_r == DPUC_CH_EVENT) begin
            if (evt_edge) begin
              count_r <= reload_r;
              state_r <= DPUC_COUNT;
            end
          end else begin
            count_r <= reload_r;
            state_r <= DPUC_COUNT;
          end
        end
        DPUC_COUNT: begin
          if (ch_mode_r == DPUC_CH_EVENT && !evt_edge) begin
            count_r <= count_r;
          end else if (count_r != 16'h0000) begin
            count_r <= count_r - 16'h0001;
          end else if (ch_mode_r == DPUC_CH_ONESHOT) begin
            state_r <= DPUC_ARMED;
          end else begin
            count_r <= reload_r;
          end
          if (start_wr && ch_mode_r == DPUC_CH_ONESHOT) begin
            count_r <= reload_r;
          end
        end
        default: begin
          state_r <= DPUC_IDLE;
        end
      endcase
    end
  end

  assign tick = (state_r == DPUC_COUNT) && (count_r == 16'h0000)
                && (ch_mode_r != DPUC_CH_EVENT || evt_edge);

  // ==========================================================
  // Interrupt request flag register; set beats clear
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      flag_r <= `DPUC_RST_IRQ_FLAG;
    end else begin
      if (req.wr && req.addr == `DPUC_OFF_IRQ_FLAG) begin
        flag_r <= req.wdata;
      end
      if (tick) begin
        flag_r[`DPUC_BIT_TMR_IRQ] <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      mask_r  <= `DPUC_RST_IRQ_MASK;
      imask_r <= `DPUC_RST_INT_MASK;
    end else if (req.wr) begin
      if (req.addr == `DPUC_OFF_IRQ_MASK) begin
        mask_r <= req.wdata;
      end
      if (req.addr == `DPUC_OFF_INT_MASK) begin
        imask_r <= req.wdata;
      end
    end
  end

  // Request leaves for service only while mask bit is clear
  assign tmr_irq_o = flag_r[`DPUC_BIT_TMR_IRQ]
                     && !mask_r[`DPUC_BIT_TMR_IRQ];

  // ==========================================================
  // Sticky status: bit0 timer tick, bit1 channel start
  assign events = {6'h00, start_wr, tick};
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      ist_r <= 8'h00;
    end else if (req.rd && req.addr == `DPUC_OFF_INT_STAT) begin
      ist_r <= events;
    end else begin
      ist_r <= ist_r | events;
    end
  end
  assign irq_o = |(ist_r & imask_r);

  // ==========================================================
  // Read port
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= 8'h00;
    end else if (req.rd) begin
      unique case (req.addr)
        `DPUC_OFF_MODE:      rdata_o <= gate_r ? mode_r : 8'h00;
        `DPUC_OFF_VALUE:     rdata_o <= gate_r ? value_r : 8'h00;
        `DPUC_OFF_IRQ_FLAG:  rdata_o <= flag_r;
        `DPUC_OFF_IRQ_MASK:  rdata_o <= mask_r;
        `DPUC_OFF_CLK_GATE:  rdata_o <= {gate_r, 7'h00};
        `DPUC_OFF_RELOAD_LO: rdata_o <= reload_r[7:0];
        `DPUC_OFF_RELOAD_HI: rdata_o <= reload_r[15:8];
        `DPUC_OFF_CH_MODE:   rdata_o <= {6'h00, ch_mode_r};
        `DPUC_OFF_STATUS:    rdata_o <= {6'h00, state_r == DPUC_COUNT,
                                         enabled_r};
        `DPUC_OFF_INT_STAT:  rdata_o <= ist_r;
        `DPUC_OFF_INT_MASK:  rdata_o <= imask_r;
        default:             rdata_o <= 8'h00;
      endcase
    end
  end

  // ==========================================================
  // Converter core
  assign conv = '{run_en:  mode_r[`DPUC_BIT_RUN_EN] && gate_r,
                  rt_mode: mode_r[`DPUC_BIT_MODE_SEL],
                  value:   value_r};

  dpuc_pwm_out u_pwm (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .conv_i  (conv),
    .load_i  (tick),
    .pin_o   (pin_o)
  );

endmodule
`default_nettype wire

// *** testbench/dpuc_top_sva.sv ***
// Purpose: Port-level checks for the converter control block
// Assumes: Register map as in dpuc_map.svh
// Notes:   Helper flops mirror gate, run, mask bits from bus writes
`timescale 1ns/10ps
`default_nettype none
`include "dpuc_map.svh"

module dpuc_top_sva (
  input wire logic       clock_i,   // Clock
  input wire logic       rst_i,     // Async reset, high
  input wire logic [3:0] addr_i,    // Register address
  input wire logic [7:0] wdata_i,   // Write data
  input wire logic       wr_i,      // Write strobe
  input wire logic       rd_i,      // Read strobe
  input wire logic       evt_pin_i, // Event pin
  input wire logic [7:0] rdata_o,   // Read data
  input wire logic       irq_o,     // Level interrupt
  input wire logic       tmr_irq_o, // Channel 0 request
  input wire logic       pin_o      // Analog output pin
);
  logic       gate_r;
  logic       run_r;
  logic       msk_r;
  logic [7:0] im_r;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  // ==========================================================
  // Mirrors of the control bits
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) gate_r <= 1'b0;
    else if (wr_i && addr_i == `DPUC_OFF_CLK_GATE) gate_r <= wdata_i[7];
  end
  // Gate low clears run as well, since the converter sits in reset
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) run_r <= 1'b0;
    else if (wr_i && addr_i == `DPUC_OFF_CLK_GATE && !wdata_i[7])
      run_r <= 1'b0;
    else if (wr_i && addr_i == `DPUC_OFF_MODE && gate_r) run_r <= wdata_i[4];
  end
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) msk_r <= 1'b1;
    else if (wr_i && addr_i == `DPUC_OFF_IRQ_MASK) msk_r <= wdata_i[4];
  end
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) im_r <= `DPUC_RST_INT_MASK;
    else if (wr_i && addr_i == `DPUC_OFF_INT_MASK) im_r <= wdata_i;
  end

  // ==========================================================
  // Assertions
  chk_rdata_hold: assert property (!rd_i |=> $stable(rdata_o))
    else $error("read data moved without a read");
  chk_unmapped_zero: assert property (rd_i && addr_i > `DPUC_OFF_INT_MASK
    |=> rdata_o == 8'h00) else $error("unmapped read not zero");
  chk_value_back: assert property (
    (wr_i && addr_i == `DPUC_OFF_VALUE && gate_r) ##1
    (rd_i && addr_i == `DPUC_OFF_VALUE) |=> rdata_o == $past(wdata_i, 2))
    else $error("conversion value readback wrong");
  chk_gate_block: assert property (
    !gate_r && rd_i && addr_i == `DPUC_OFF_VALUE |=> rdata_o == 8'h00)
    else $error("value visible while gated");
  chk_tmr_mask: assert property (tmr_irq_o |-> !msk_r)
    else $error("masked channel request forwarded");
  chk_flag_read: assert property (
    rd_i && addr_i == `DPUC_OFF_IRQ_FLAG && tmr_irq_o |=> rdata_o[4])
    else $error("pending flag read as clear");
  chk_irq_cause: assert property (irq_o |-> im_r != 8'h00)
    else $error("interrupt with all sources masked");
  chk_pin_off: assert property (!run_r [*3] |-> !pin_o)
    else $error("pin active while converter stopped");
  chk_start_status: assert property (
    (wr_i && addr_i == `DPUC_OFF_START_LO && wdata_i[0]) ##1
    (rd_i && addr_i == `DPUC_OFF_STATUS) |=> rdata_o[0])
    else $error("start did not enable channel");
  chk_start_zero: assert property (
    (rd_i && addr_i == `DPUC_OFF_STATUS) ##1
    (wr_i && addr_i == `DPUC_OFF_START_LO && !wdata_i[0]) ##1
    (rd_i && addr_i == `DPUC_OFF_STATUS) |=> rdata_o == $past(rdata_o, 2))
    else $error("zero start write changed status");
endmodule

bind dpuc_top dpuc_top_sva chk_u (.clock_i(clock_i), .rst_i(rst_i),
  .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
  .evt_pin_i(evt_pin_i), .rdata_o(rdata_o), .irq_o(irq_o),
  .tmr_irq_o(tmr_irq_o), .pin_o(pin_o));
`default_nettype wire

// *** testbench/testbench.sv ***
// Purpose: Self-checking bench for the converter control block
// Assumes: Register map as in dpuc_map.svh
// Notes:   Reads are checked by a monitor against a queue of notes
`timescale 1ns/10ps
`default_nettype none
`include "dpuc_map.svh"

module testbench;
  import dpuc_pkg::*;
  localparam logic [15:0] RLD = `DPUC_RST_RELOAD;
  logic        clock_i, rst_i, wr_i, rd_i, evt_pin_i, rd_q;
  logic        irq_o, tmr_irq_o, pin_o;
  logic [3:0]  addr_i;
  logic [7:0]  wdata_i, rdata_o, v;
  logic [15:0] nt;
  logic [15:0] exp_q[$];
  int          fails, n_tests, cyc;

  dpuc_top dut_u (.clock_i(clock_i), .rst_i(rst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .evt_pin_i(evt_pin_i),
    .rdata_o(rdata_o), .irq_o(irq_o), .tmr_irq_o(tmr_irq_o), .pin_o(pin_o));

  // ==========================================================
  // Checking and bus tasks
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic results();
    $display("mismatches %0d of %0d checks", fails, n_tests);
    if (fails == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic bus(input logic [3:0] a, input logic [7:0] d,
                     input logic w, input logic r);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= w;
    rd_i <= r;
    @(posedge clock_i);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    bus(a, d, 1'b1, 1'b0);
  endtask
  // Only bits set in m are compared; timer ticks move the others
  task automatic rd(input logic [3:0] a, input logic [7:0] e,
                    input logic [7:0] m);
    exp_q.push_back({m, e});
    bus(a, 8'h00, 1'b0, 1'b1);
  endtask
  task automatic idle(input int n);
    bus(4'h0, 8'h00, 1'b0, 1'b0);
    repeat (n - 1) @(posedge clock_i);
  endtask
  // Any 256-cycle window covers each duty step once
  task automatic duty(input logic [7:0] e);
    int h;
    h = 0;
    idle(260);
    repeat (256) begin
      @(posedge clock_i);
      if (pin_o === 1'b1) h++;
    end
    chk(9'(h), {1'b0, e});
  endtask

  // ==========================================================
  // Clock, monitor, timeout
  initial begin
    clock_i = 1'b0;
    forever #2.5 clock_i = ~clock_i;
  end
  always @(posedge clock_i) begin
    rd_q <= rd_i;
    if (rd_q === 1'b1) begin
      nt = exp_q.pop_front();
      chk({1'b0, rdata_o & nt[15:8]}, {1'b0, nt[7:0] & nt[15:8]});
    end
  end
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 8000) begin
      fails++;
      results();
    end
  end

  // ==========================================================
  // Main sequence
  initial begin
    rst_i = 1'b1; addr_i = 4'h0; wdata_i = 8'h00; wr_i = 1'b0;
    rd_i = 1'b0; evt_pin_i = 1'b0; rd_q = 1'b0;
    fails = 0; n_tests = 0; cyc = 0;
    void'($urandom(32'h6c63));
    repeat (20) @(posedge clock_i);
    rst_i <= 1'b0;
    @(posedge clock_i);
    rd(`DPUC_OFF_MODE, `DPUC_RST_MODE, 8'hff);
    rd(`DPUC_OFF_IRQ_FLAG, `DPUC_RST_IRQ_FLAG, 8'hff);
    rd(`DPUC_OFF_IRQ_MASK, `DPUC_RST_IRQ_MASK, 8'hff);
    rd(`DPUC_OFF_RELOAD_LO, RLD[7:0], 8'hff);
    rd(`DPUC_OFF_RELOAD_HI, RLD[15:8], 8'hff);
    rd(`DPUC_OFF_INT_MASK, `DPUC_RST_INT_MASK, 8'hff);
    rd(4'hf, 8'h00, 8'hff);
    wr(`DPUC_OFF_VALUE, 8'ha5);
    rd(`DPUC_OFF_VALUE, 8'h00, 8'hff);
    wr(`DPUC_OFF_CLK_GATE, 8'h80);
    wr(`DPUC_OFF_VALUE, 8'h80);
    rd(`DPUC_OFF_VALUE, 8'h80, 8'hff);
    duty(8'h00);
    wr(`DPUC_OFF_MODE, 8'h10);
    rd(`DPUC_OFF_MODE, 8'h10, 8'h11);
    for (int i = 0; i < 5; i++) begin
      v = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($urandom);
      wr(`DPUC_OFF_VALUE, v);
      rd(`DPUC_OFF_VALUE, v, 8'hff);
      duty(v);
    end
    wr(`DPUC_OFF_MODE, 8'h00);
    duty(8'h00);
    wr(`DPUC_OFF_RELOAD_LO, 8'h09);
    wr(`DPUC_OFF_RELOAD_HI, 8'h00);
    wr(`DPUC_OFF_CH_MODE, 8'h00);
    wr(`DPUC_OFF_INT_MASK, 8'h02);
    wr(`DPUC_OFF_IRQ_MASK, 8'hef);
    rd(`DPUC_OFF_STATUS, 8'h00, 8'h01);
    wr(`DPUC_OFF_START_LO, 8'h00);
    rd(`DPUC_OFF_STATUS, 8'h00, 8'h01);
    idle(2);
    chk({8'h00, irq_o}, 9'h000);
    wr(`DPUC_OFF_START_LO, 8'h01);
    rd(`DPUC_OFF_STATUS, 8'h01, 8'h01);
    idle(2);
    chk({8'h00, irq_o}, 9'h001);
    for (int k = 0; k < 40 && tmr_irq_o !== 1'b1; k++) @(posedge clock_i);
    chk({8'h00, tmr_irq_o}, 9'h001);
    rd(`DPUC_OFF_IRQ_FLAG, 8'h10, 8'h10);
    wr(`DPUC_OFF_IRQ_MASK, 8'hff);
    idle(1);
    chk({8'h00, tmr_irq_o}, 9'h000);
    wr(`DPUC_OFF_INT_MASK, 8'h00);
    idle(1);
    chk({8'h00, irq_o}, 9'h000);
    rd(`DPUC_OFF_INT_STAT, 8'h02, 8'h02);
    wr(`DPUC_OFF_INT_MASK, 8'h02);
    idle(1);
    chk({8'h00, irq_o}, 9'h000);
    // Event mode with a quiet pin gives no tick, so real-time code holds
    wr(`DPUC_OFF_CH_MODE, 8'h01);
    wr(`DPUC_OFF_MODE, 8'h11);
    wr(`DPUC_OFF_VALUE, ~v);
    wr(`DPUC_OFF_IRQ_FLAG, 8'h00);
    rd(`DPUC_OFF_IRQ_FLAG, 8'h00, 8'h10);
    duty(v);
    repeat (12) begin
      evt_pin_i <= 1'b1;
      idle(4);
      evt_pin_i <= 1'b0;
      idle(4);
    end
    rd(`DPUC_OFF_IRQ_FLAG, 8'h10, 8'h10);
    duty(~v);
    wr(`DPUC_OFF_CH_MODE, 8'h02);
    wr(`DPUC_OFF_IRQ_FLAG, 8'h00);
    idle(30);
    rd(`DPUC_OFF_IRQ_FLAG, 8'h10, 8'h10);
    wr(`DPUC_OFF_CLK_GATE, 8'h00);
    rd(`DPUC_OFF_VALUE, 8'h00, 8'hff);
    rd(`DPUC_OFF_MODE, 8'h00, 8'hff);
    idle(4);
    results();
  end
endmodule
`default_nettype wire
